// ===== rtl/rgcs_pkg.sv
// Shared constants and types of the receive gain compensation and slicer block
package rgcs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Structure
  localparam int NUM_RX = 4;
  localparam int GPIO_W = 16;
  localparam int SAMPLE_W = 16;
  localparam int NARROW_W = 12;
  localparam int OUT_W = 24;
  localparam int IDX_W = 8;
  localparam int ATTEN_W = 8;
  localparam int GAIN_W = 7;
  localparam int SLA_W = 8;
  localparam int POS_W = 4;
  localparam int WIDE_W = 26;
  localparam int PROD_W = 28;
  localparam int PROD2_W = 38;
  localparam int MANT_W = 11;
  localparam int MANT_FRAC = 10;
  localparam int TABLE_DEPTH = 256;
  localparam int TABLE_W = ATTEN_W + GAIN_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Gain arithmetic, all gains counted in half decibels
  localparam logic [GAIN_W-1:0] MAX_GAIN_HALF = 7'h64;
  localparam logic [GAIN_W-1:0] GAIN_HALF_PER_BIT = 7'h0c;
  localparam logic [SLA_W-1:0] SLA_HALF_PER_BIT = 8'h0c;
  localparam logic [GAIN_W-1:0] GAIN_ZERO = 7'h00;
  localparam logic [POS_W-1:0] POS_REST = 4'h0;
  localparam logic [POS_W-1:0] POS_MAX = 4'hf;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 16'sh7fff;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = -16'sh8000;

  // Linear gain of 0 to 5.5 dB in half dB steps, scaled by 2^10
  localparam logic [MANT_W-1:0] GAIN_MANT [12] = '{
    11'h400, 11'h43d, 11'h47d, 11'h4c1, 11'h509, 11'h556,
    11'h5a6, 11'h5fc, 11'h657, 11'h6b7, 11'h71d, 11'h789};
  // Linear loss of 0 to 5.5 dB in half dB steps, scaled by 2^10
  localparam logic [MANT_W-1:0] ATTEN_MANT [12] = '{
    11'h400, 11'h3c7, 11'h390, 11'h35d, 11'h32d, 11'h2ff,
    11'h2d4, 11'h2ab, 11'h285, 11'h261, 11'h23f, 11'h21e};

  ////////////////////////////////////////////////////////////////////////////////
  // Slicer step size and link width selections
  typedef enum logic [2:0] {
    STEP_1DB = 3'h0,
    STEP_2DB = 3'h1,
    STEP_3DB = 3'h2,
    STEP_4DB = 3'h3,
    STEP_6DB = 3'h4,
    STEP_8DB = 3'h5
  } rgcs_step_type;
  localparam logic [SLA_W-1:0] STEP_HALF [6] = '{
    8'h02, 8'h04, 8'h06, 8'h08, 8'h0c, 8'h10};

  typedef enum logic [1:0] {
    WIDTH_12 = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_24 = 2'h2
  } rgcs_width_type;

  // Lowest pin of each receiver's four position pins
  localparam logic [3:0] PIN_BASE [NUM_RX] = '{4'h8, 4'hc, 4'h4, 4'h0};

endpackage

// ===== rtl/rgcs_gain_mem.sv
// Gain table of one receiver: attenuator setting and digital gain per index
`timescale 1ns/10ps
module rgcs_gain_mem
  import rgcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_addr,
  input wire logic [TABLE_W-1:0] wr_data,
  input wire logic [IDX_W-1:0] rd_addr,
  output logic [TABLE_W-1:0] rd_data
);

  logic [TABLE_W-1:0] mem [TABLE_DEPTH];

  // Array has no reset, so entries are unknown until software loads the table
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read costs one cycle of latency in the sample path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // rgcs_gain_mem

// ===== rtl/rgcs_slicer_pos.sv
// Slicer position and slicer attenuation from the applied digital gain
`timescale 1ns/10ps
module rgcs_slicer_pos
  import rgcs_pkg::*;
(
  input wire logic [GAIN_W-1:0] gain_half,
  input wire logic [2:0] step_sel,
  output logic [POS_W-1:0] pos,
  output logic [SLA_W-1:0] atten_half
);

  logic [GAIN_W-1:0] quot;
  logic [SLA_W-1:0] step_half;
  logic [SLA_W-1:0] raw;

  // Constant divisors per step keep each divider small
  always_comb begin
    quot = '0;
    step_half = STEP_HALF[STEP_6DB];
    raw = '0;
    pos = POS_REST;
    case (step_sel)
      STEP_1DB: quot = gain_half / 7'h02;
      STEP_2DB: quot = gain_half / 7'h04;
      STEP_3DB: quot = gain_half / 7'h06;
      STEP_4DB: quot = gain_half / 7'h08;
      STEP_8DB: quot = gain_half / 7'h10;
      default: quot = gain_half / 7'h0c;
    endcase
    if (step_sel <= STEP_8DB) begin
      step_half = STEP_HALF[step_sel];
    end
    raw = SLA_W'(quot) + 8'h01;
    // Zero gain rests at zero, else quotient plus one; four pins cap range
    if (gain_half == GAIN_ZERO) begin
      pos = POS_REST;
    end else if (raw > SLA_W'(POS_MAX)) begin
      pos = POS_MAX;
    end else begin
      pos = POS_W'(raw);
    end
    atten_half = SLA_W'(pos * step_half);
  end

endmodule // rgcs_slicer_pos

// ===== rtl/rgcs_rx_gain_comp_slicer.sv
// Four-receiver digital gain compensation, slicer and slicer position pins
`timescale 1ns/10ps

module rgcs_rx_gain_comp_slicer
  import rgcs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic COMP_EN,
  input wire logic [2:0] SLICER_STEP,
  input wire logic [1:0] LINK_WIDTH,
  input wire logic [NUM_RX-1:0] AGC_MODE,
  input wire logic [NUM_RX-1:0][IDX_W-1:0] AGC_GAIN_INDEX,
  input wire logic [NUM_RX-1:0][IDX_W-1:0] MGC_GAIN_INDEX,
  input wire logic [NUM_RX-1:0] RX_IN_VALID,
  input wire logic [NUM_RX-1:0][SAMPLE_W-1:0] RX_IN_DATA,
  input wire logic TABLE_WE,
  input wire logic [1:0] TABLE_RX,
  input wire logic [IDX_W-1:0] TABLE_ADDR,
  input wire logic [ATTEN_W-1:0] TABLE_ATTEN,
  input wire logic [GAIN_W-1:0] TABLE_GAIN,
  input wire logic [GPIO_W-1:0] GPIO_OUT_ENABLE,
  input wire logic [GPIO_W-1:0] GPIO_SLICER_FUNC,
  input wire logic [GPIO_W-1:0] GPIO_OTHER_DATA,
  output logic [NUM_RX-1:0] RX_OUT_VALID,
  output logic [NUM_RX-1:0][OUT_W-1:0] RX_OUT_DATA,
  output logic [NUM_RX-1:0][ATTEN_W-1:0] AFE_ATTEN,
  output logic [GPIO_W-1:0] GPIO_OUT,
  output logic [GPIO_W-1:0] GPIO_OE
);

  typedef struct packed {
    logic comp;
    logic [2:0] step;
    logic [1:0] width;
    logic [NUM_RX-1:0] s1_valid;
    logic [NUM_RX-1:0][SAMPLE_W-1:0] s1_data;
    logic [NUM_RX-1:0] s2_valid;
    logic [NUM_RX-1:0][WIDE_W-1:0] s2_wide;
    logic [NUM_RX-1:0][GAIN_W-1:0] s2_gain;
    logic [NUM_RX-1:0][POS_W-1:0] pos;
    logic [NUM_RX-1:0][SLA_W-1:0] atten_half;
    logic [NUM_RX-1:0] out_valid;
    logic [NUM_RX-1:0][OUT_W-1:0] out_data;
    logic [NUM_RX-1:0][ATTEN_W-1:0] afe_atten;
    logic [GPIO_W-1:0] gpio_out;
    logic [GPIO_W-1:0] gpio_oe;
  } rgcs_state_type;

  rgcs_state_type s;
  rgcs_state_type next_s;

  logic [NUM_RX-1:0][IDX_W-1:0] rd_index;
  logic [NUM_RX-1:0][TABLE_W-1:0] rd_entry;
  logic [NUM_RX-1:0][GAIN_W-1:0] gain_c;
  logic [NUM_RX-1:0][POS_W-1:0] pos_c;
  logic [NUM_RX-1:0][SLA_W-1:0] sla_c;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clamp any wider result into the sixteen-bit sample range
  function automatic logic [SAMPLE_W-1:0] sat16(input logic signed [PROD2_W-1:0] v);
    logic [SAMPLE_W-1:0] r;
    r = v[SAMPLE_W-1:0];
    if (v > PROD2_W'(SAMPLE_MAX)) begin
      r = SAMPLE_MAX;
    end else if (v < PROD2_W'(SAMPLE_MIN)) begin
      r = SAMPLE_MIN;
    end
    return r;
  endfunction

  // Place a sixteen-bit sample on the link word; narrow widths sign-extend
  function automatic logic [OUT_W-1:0] fmt(input logic [SAMPLE_W-1:0] x,
                                           input logic [1:0] w);
    logic [OUT_W-1:0] r;
    r = {{(OUT_W-SAMPLE_W){x[SAMPLE_W-1]}}, x};
    case (w)
      WIDTH_12: r = {{(OUT_W-NARROW_W){x[SAMPLE_W-1]}}, x[SAMPLE_W-1 -: NARROW_W]};
      WIDTH_24: r = {x, {(OUT_W-SAMPLE_W){1'b0}}};
      default: r = {{(OUT_W-SAMPLE_W){x[SAMPLE_W-1]}}, x};
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Per-receiver gain table and slicer position

  genvar g;
  generate
    for (g = 0; g < NUM_RX; g++) begin : gen_rx
      // Automatic or manual index, both feed the same compensation path
      assign rd_index[g] = AGC_MODE[g] ? AGC_GAIN_INDEX[g] : MGC_GAIN_INDEX[g];
      // Gain above the ceiling is held at fifty decibels
      assign gain_c[g] = (rd_entry[g][GAIN_W-1:0] > MAX_GAIN_HALF) ? MAX_GAIN_HALF
                         : rd_entry[g][GAIN_W-1:0];

      rgcs_gain_mem u_table (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .wr_en(TABLE_WE && (TABLE_RX == 2'(g))),
        .wr_addr(TABLE_ADDR),
        .wr_data({TABLE_ATTEN, TABLE_GAIN}),
        .rd_addr(rd_index[g]),
        .rd_data(rd_entry[g])
      );

      rgcs_slicer_pos u_pos (
        .gain_half(gain_c[g]),
        .step_sel(s.step),
        .pos(pos_c[g]),
        .atten_half(sla_c[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [3:0] k;
    logic [3:0] r;
    logic [3:0] ka;
    logic [3:0] ra;
    logic signed [PROD_W-1:0] prod;
    logic signed [WIDE_W-1:0] wide;
    logic signed [WIDE_W-1:0] shifted;
    logic signed [PROD2_W-1:0] prod2;
    logic [4:0] pin;
    k = '0;
    r = '0;
    ka = '0;
    ra = '0;
    prod = '0;
    wide = '0;
    shifted = '0;
    prod2 = '0;
    pin = '0;
    next_s = s;
    next_s.comp = COMP_EN;
    next_s.step = SLICER_STEP;
    next_s.width = LINK_WIDTH;
    next_s.gpio_oe = GPIO_OUT_ENABLE;
    for (int i = 0; i < NUM_RX; i++) begin
      // Stage 1: table read under way, hold the sample alongside it
      next_s.s1_valid[i] = RX_IN_VALID[i];
      next_s.s1_data[i] = RX_IN_DATA[i];
      // Stage 2: apply table gain as mantissa times a power of two
      k = 4'(gain_c[i] / GAIN_HALF_PER_BIT);
      r = 4'(gain_c[i] % GAIN_HALF_PER_BIT);
      prod = PROD_W'($signed(s.s1_data[i]) * $signed({1'b0, GAIN_MANT[r]}));
      wide = WIDE_W'(prod >>> MANT_FRAC);
      wide = wide <<< k;
      next_s.s2_valid[i] = s.s1_valid[i];
      next_s.s2_wide[i] = wide;
      next_s.s2_gain[i] = gain_c[i];
      next_s.afe_atten[i] = rd_entry[i][TABLE_W-1 -: ATTEN_W];
      // Slicer bypassed when compensation is off, position rests at zero
      next_s.pos[i] = s.comp ? pos_c[i] : POS_REST;
      next_s.atten_half[i] = s.comp ? sla_c[i] : '0;
      // Stage 3: slice by whole bits, then any fractional dB remainder
      ka = 4'(s.atten_half[i] / SLA_HALF_PER_BIT);
      ra = 4'(s.atten_half[i] % SLA_HALF_PER_BIT);
      // Signed view of the widened word, so negative samples shift in their sign
      shifted = $signed(s.s2_wide[i]) >>> ka;
      prod2 = PROD2_W'(shifted * $signed({1'b0, ATTEN_MANT[ra]}));
      prod2 = prod2 >>> MANT_FRAC;
      // Without slicing the word is clamped, so it never grows past sixteen
      next_s.out_valid[i] = s.s2_valid[i];
      next_s.out_data[i] = fmt(sat16(prod2), s.width);
    end
    // Pins follow the position as it is registered, ahead of its samples
    for (int i = 0; i < NUM_RX; i++) begin
      for (int b = 0; b < POS_W; b++) begin
        pin = 5'(PIN_BASE[i]) + 5'(b);
        if (!GPIO_OUT_ENABLE[pin[3:0]]) begin
          next_s.gpio_out[pin[3:0]] = 1'b0;
        end else if (GPIO_SLICER_FUNC[pin[3:0]]) begin
          next_s.gpio_out[pin[3:0]] = next_s.pos[i][b];
        end else begin
          next_s.gpio_out[pin[3:0]] = GPIO_OTHER_DATA[pin[3:0]];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset clears compensation and rests every position

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign RX_OUT_VALID = s.out_valid;
  assign RX_OUT_DATA = s.out_data;
  assign AFE_ATTEN = s.afe_atten;
  assign GPIO_OUT = s.gpio_out;
  assign GPIO_OE = s.gpio_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  reset_mode_a: assert property ($rose(RST_N) |-> !s.comp && s.pos == '0)
    else $error("compensation or position not cleared by reset");

  oe_follow_a: assert property ($past(RST_N) |-> GPIO_OE == $past(GPIO_OUT_ENABLE))
    else $error("pin enable does not follow its control");

  generate
    for (g = 0; g < NUM_RX; g++) begin : gen_chk
      // A zero-gain sample entering, and a sample reaching the six-dB slicer
      sequence zero_gain_in_s;
        s.s1_valid[g] && s.comp && COMP_EN && (gain_c[g] == GAIN_ZERO);
      endsequence
      sequence six_step_s;
        s.s2_valid[g] && s.comp && (s.step == STEP_6DB) && (s.width == WIDTH_16);
      endsequence

      gain_cap_a: assert property (s.s2_gain[g] <= MAX_GAIN_HALF)
        else $error("digital gain above fifty decibels");

      pos_rest_a: assert property (
        s.comp && s.s2_gain[g] == GAIN_ZERO |-> s.pos[g] == '0)
        else $error("position not at rest with zero gain");

      pos_six_a: assert property (
        s.comp && s.step == STEP_6DB && $past(s.comp) && $past(s.step) == STEP_6DB
        && s.s2_gain[g] != GAIN_ZERO
        |-> s.pos[g] == 4'(s.s2_gain[g] / GAIN_HALF_PER_BIT) + 4'h1)
        else $error("six decibel position wrong");

      bypass_pos_a: assert property (
        !$past(s.comp) |-> s.pos[g] == '0 && s.atten_half[g] == '0)
        else $error("slicer active while uncompensated");

      zero_db_a: assert property (
        zero_gain_in_s ##1 (s.width == WIDTH_16)
        |=> RX_OUT_DATA[g][SAMPLE_W-1:0] == $past(s.s1_data[g], 2))
        else $error("net gain not zero at zero table gain");

      slice_top_a: assert property (
        six_step_s |=> RX_OUT_DATA[g][SAMPLE_W-1:0]
        == SAMPLE_W'($signed($past(s.s2_wide[g])) >>> $past(s.pos[g])))
        else $error("slicer did not keep the sixteen top bits");

      widen_a: assert property (
        s.s2_valid[g] |-> ($signed(s.s2_wide[g])
        >>> (SAMPLE_W + 32'(s.s2_gain[g] / GAIN_HALF_PER_BIT))) inside {'0, '1})
        else $error("widened word exceeds one bit per six decibels");

      atten_a: assert property (##1 AFE_ATTEN[g] == $past(rd_entry[g][TABLE_W-1 -: ATTEN_W]))
        else $error("attenuator setting does not follow the table");

      pins_a: assert property (
        GPIO_OUT_ENABLE[PIN_BASE[g]] && GPIO_SLICER_FUNC[PIN_BASE[g]]
        |=> GPIO_OUT[PIN_BASE[g]] == s.pos[g][0])
        else $error("position bit missing from its pin");

      pin_off_a: assert property (
        !GPIO_OUT_ENABLE[PIN_BASE[g] + 4'h3] |=> !GPIO_OUT[PIN_BASE[g] + 4'h3])
        else $error("disabled position pin not held low");

      pin_other_a: assert property (
        GPIO_OUT_ENABLE[PIN_BASE[g] + 4'h2] && !GPIO_SLICER_FUNC[PIN_BASE[g] + 4'h2]
        |=> GPIO_OUT[PIN_BASE[g] + 4'h2] == $past(GPIO_OTHER_DATA[PIN_BASE[g] + 4'h2]))
        else $error("pin not handed to its other function");

      latency_a: assert property (s.s1_valid[g] |-> ##2 RX_OUT_VALID[g])
        else $error("sample lost in the pipeline");
    end
  endgenerate

endmodule // rgcs_rx_gain_comp_slicer

// ===== tb/rgcs_bb_model.sv
// Baseband receiver model: takes samples and slicer position and restores input level
`timescale 1ns/10ps
module rgcs_bb_model
  import rgcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_RX-1:0] rx_valid,
  input wire logic [NUM_RX-1:0][OUT_W-1:0] rx_data,
  input wire logic [GPIO_W-1:0] gpio,
  output logic [OUT_W-1:0] rescaled
);
  logic [POS_W-1:0] pos_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins lead the data by one cycle, so the position is delayed to meet its samples.
  // Only receiver zero is modelled, and only for six-dB steps (one bit per position).
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_d <= 4'h0;
      rescaled <= '0;
    end else begin
      pos_d <= gpio[11:8];
      if (rx_valid[0]) begin
        rescaled <= rx_data[0] <<< pos_d;
      end
    end
  end
endmodule // rgcs_bb_model

// ===== tb/tb_top.sv
// Self-checking bench of the receive gain compensation and slicer block
`timescale 1ns/10ps
module tb_top
  import rgcs_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic comp_en = 1'b0;
  logic [2:0] step = 3'h4;
  logic [1:0] width = 2'h1;
  logic [NUM_RX-1:0] agc_mode = 4'h5;
  logic [NUM_RX-1:0][IDX_W-1:0] agc_idx = '0;
  logic [NUM_RX-1:0][IDX_W-1:0] mgc_idx = '0;
  logic [NUM_RX-1:0] in_valid = '0;
  logic [NUM_RX-1:0][SAMPLE_W-1:0] in_data = '0;
  logic tbl_we = 1'b0;
  logic [1:0] tbl_rx = 2'h0;
  logic [IDX_W-1:0] tbl_addr = '0;
  logic [ATTEN_W-1:0] tbl_atten = '0;
  logic [GAIN_W-1:0] tbl_gain = '0;
  logic [GPIO_W-1:0] oe = 16'hffff;
  logic [GPIO_W-1:0] fn = 16'hffff;
  logic [GPIO_W-1:0] oth = 16'h5a5a;
  logic [NUM_RX-1:0] out_valid;
  logic [NUM_RX-1:0][OUT_W-1:0] out_data;
  logic [NUM_RX-1:0][ATTEN_W-1:0] afe_atten;
  logic [GPIO_W-1:0] gpio_out;
  logic [GPIO_W-1:0] gpio_oe;
  logic [OUT_W-1:0] bb_rescaled;
  // Table gains in half dB at addresses 0 to 7; the last one is past the cap
  logic [GAIN_W-1:0] gl [8] = '{7'h00, 7'h01, 7'h0b, 7'h0c, 7'h18, 7'h5f, 7'h60, 7'h7f};
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  rgcs_rx_gain_comp_slicer dut (.CORE_CLK(core_clk), .RST_N(rst_n), .COMP_EN(comp_en),
    .SLICER_STEP(step), .LINK_WIDTH(width), .AGC_MODE(agc_mode), .AGC_GAIN_INDEX(agc_idx),
    .MGC_GAIN_INDEX(mgc_idx), .RX_IN_VALID(in_valid), .RX_IN_DATA(in_data),
    .TABLE_WE(tbl_we), .TABLE_RX(tbl_rx), .TABLE_ADDR(tbl_addr), .TABLE_ATTEN(tbl_atten),
    .TABLE_GAIN(tbl_gain), .GPIO_OUT_ENABLE(oe), .GPIO_SLICER_FUNC(fn),
    .GPIO_OTHER_DATA(oth), .RX_OUT_VALID(out_valid), .RX_OUT_DATA(out_data),
    .AFE_ATTEN(afe_atten), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe));

  rgcs_bb_model bb (.clk(core_clk), .rst_n(rst_n), .rx_valid(out_valid), .rx_data(out_data),
    .gpio(gpio_out), .rescaled(bb_rescaled));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs well under a thousand cycles
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("[FAIL] run length expected below 3000 seen %0d", cycles);
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expected values
  function automatic logic [3:0] pos_of(input logic [6:0] g, input logic [2:0] s);
    logic [7:0] gc;
    logic [7:0] sh;
    logic [7:0] p;
    gc = (g > 7'h64) ? 8'h64 : {1'b0, g};
    sh = (s == 3'h5) ? 8'h10 : (s == 3'h4) ? 8'h0c : {4'h0, s + 3'h1, 1'b0};
    p = gc / sh + 8'h01;
    if (gc == 8'h00) begin
      p = 8'h00;
    end
    return (p > 8'h0f) ? 4'hf : p[3:0];
  endfunction

  // Valid only for gains that are whole multiples of six dB
  function automatic logic [23:0] data_of(input logic [15:0] x, input logic [6:0] g,
                                          input logic c, input logic [1:0] w);
    logic signed [25:0] v;
    logic [15:0] s;
    v = 26'(signed'(x)) <<< (g / 7'h0c);
    if (c) begin
      v = v >>> pos_of(g, 3'h4);
    end
    s = (v > 26'sh7fff) ? 16'h7fff : (v < -26'sh8000) ? 16'h8000 : v[15:0];
    return (w == 2'h0) ? {{12{s[15]}}, s[15:4]} : (w == 2'h2) ? {s, 8'h00} : {{8{s[15]}}, s};
  endfunction

  // Pins 15..12 rx1, 11..8 rx0, 7..4 rx2, 3..0 rx3
  function automatic logic [15:0] gpio_of(input logic [3:0][3:0] p, input logic [15:0] e,
                                          input logic [15:0] f, input logic [15:0] o);
    logic [15:0] v;
    v = {p[1], p[0], p[2], p[3]};
    return e & ((f & v) | (~f & o));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic load(input int a);
    for (int r = 0; r < NUM_RX; r++) begin
      @(posedge core_clk);
      tbl_we <= 1'b1;
      tbl_rx <= 2'(r);
      tbl_addr <= 8'(a);
      tbl_atten <= {1'b0, gl[a]};
      tbl_gain <= gl[a];
    end
    @(posedge core_clk);
    tbl_we <= 1'b0;
  endtask

  task automatic cfg(input logic c, input logic [2:0] s, input logic [1:0] w,
                     input logic [3:0] m);
    @(posedge core_clk);
    comp_en <= c;
    step <= s;
    width <= w;
    agc_mode <= m;
    #1;
  endtask

  // Unused index points at an unwritten entry, so a wrong index choice shows up
  task automatic run_sample(input int a, input int rot, input logic [15:0] x);
    logic [3:0][3:0] ep;
    logic [6:0] g [NUM_RX];
    for (int r = 0; r < NUM_RX; r++) begin
      g[r] = gl[(a + rot * r) % 8];
      ep[r] = comp_en ? pos_of(g[r], step) : 4'h0;
    end
    @(posedge core_clk);
    for (int r = 0; r < NUM_RX; r++) begin
      agc_idx[r] <= agc_mode[r] ? 8'((a + rot * r) % 8) : 8'hff;
      mgc_idx[r] <= agc_mode[r] ? 8'hff : 8'((a + rot * r) % 8);
    end
    in_valid <= 4'hf;
    in_data <= {4{x}};
    @(posedge core_clk);
    in_valid <= 4'h0;
    @(posedge core_clk);
    #1;
    chk("position pins", gpio_of(ep, oe, fn, oth), gpio_out);
    chk("valid before data", 24'h0, out_valid);
    for (int r = 0; r < NUM_RX; r++) begin
      chk("attenuator", {1'b0, g[r]}, afe_atten[r]);
    end
    @(posedge core_clk);
    #1;
    chk("valid", 24'hf, out_valid);
    for (int r = 0; r < NUM_RX; r++) begin
      if (g[r] % 7'h0c == 7'h00 && (!comp_en || step == 3'h4)) begin
        chk("data", data_of(x, g[r], comp_en, width), out_data[r]);
      end
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (6) @(posedge core_clk);
    // Entry 0 is loaded under reset, so the first table read after release is defined
    load(0);
    #1;
    chk("reset valid", 24'h0, out_valid);
    chk("reset pins", 24'h0, gpio_out);
    @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 1; a < 8; a++) begin
      load(a);
    end
    // Default mode is uncompensated, so table gain still widens but no slicer
    run_sample(3, 1, 16'h4321);
    $display("test reset and default done");
    for (int w = 0; w < 3; w++) begin
      cfg(1'b0, 3'h4, 2'(w), 4'h5);
      run_sample(4, 0, 16'h1234);
      run_sample(4, 0, 16'hc000);
    end
    $display("test uncompensated widths done");
    for (int a = 0; a < 8; a++) begin
      cfg(1'b1, 3'h4, 2'h1, a[0] ? 4'ha : 4'h5);
      run_sample(a, 1, a[1] ? 16'h8010 : 16'h7ff0);
      @(posedge core_clk);
      #1;
      if (gl[a] % 7'h0c == 7'h00) begin
        chk("rescaled", 24'(signed'(a[1] ? 16'h8010 : 16'h7ff0)) <<< (gl[a] / 7'h0c), bb_rescaled);
      end
    end
    $display("test six dB slicer done");
    for (int s = 0; s < 6; s++) begin
      cfg(1'b1, 3'(s), 2'h1, 4'h5);
      run_sample(4, 0, 16'h0100);
      run_sample(7, 0, 16'h0100);
    end
    $display("test step sizes done");
    @(posedge core_clk);
    oe <= 16'h0f3c;
    fn <= 16'h33f0;
    oth <= 16'haaaa;
    cfg(1'b1, 3'h4, 2'h1, 4'h5);
    run_sample(1, 1, 16'h0100);
    chk("pin enable copy", 24'h0f3c, gpio_oe);
    $display("test pin enables done");
    final_report();
  end
endmodule // tb_top
